// >>> rtl/sas_pkg.sv
/*
  sas_pkg: constants, types and helpers for the serial slave front end.
  Assumes a 20 MHz core clock and a bus master running SCL at 400 kHz or
  below.
*/
package sas_pkg;

  // ==========================================================
  // clock and bus timing
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned T_HD_DAT_NS   = 300;  // least hold when sending
  localparam int unsigned HOLD_CYC      =
    (T_HD_DAT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0]  HOLD_CYC_W    = 4'(HOLD_CYC);

  // ==========================================================
  // slave addresses and command codes
  localparam logic [6:0] ADDR_BASE        = 7'h37;
  localparam logic [6:0] ADDR_GLOBAL      = 7'h36;
  localparam logic [6:0] ADDR_ALERT_RESP  = 7'h0C;
  localparam logic [7:0] CMD_ALERT_CLEAR  = 8'h28;  // alert_clear_location
  localparam logic       DIR_READ         = 1'b1;
  localparam logic       DIR_WRITE        = 1'b0;

  // ==========================================================
  // three-state select pin levels, as reported by the pad
  localparam logic [1:0] SEL_LOW  = 2'h0;
  localparam logic [1:0] SEL_OPEN = 2'h1;
  localparam logic [1:0] SEL_HIGH = 2'h2;

  // ==========================================================
  // byte positions within one addressed segment
  localparam logic [2:0] BYTE_ADDR = 3'h0;
  localparam logic [2:0] BYTE_CMD  = 3'h1;
  localparam logic [2:0] BYTE_LO   = 3'h2;
  localparam logic [2:0] BYTE_HI   = 3'h3;
  localparam logic [2:0] CNT_SEND  = 3'h2;  // address plus command
  localparam logic [2:0] CNT_WORD  = 3'h4;  // address, command, two data
  localparam logic [3:0] BITS_BYTE = 4'h8;

  // ==========================================================
  // synchroniser layout: scl, sda, write protect, three selects
  localparam int unsigned SYNC_W   = 9;
  localparam int unsigned SY_SCL   = 0;
  localparam int unsigned SY_SDA   = 1;
  localparam int unsigned SY_WP    = 2;
  localparam int unsigned SY_SEL_A = 3;
  localparam int unsigned SY_SEL_B = 5;
  localparam int unsigned SY_SEL_C = 7;
  localparam logic [SYNC_W-1:0] SYNC_RST = 9'h007;  // lines idle high

  // ==========================================================
  // types
  typedef enum logic [4:0] {
    ST_IDLE   = 5'b00001,
    ST_RX     = 5'b00010,
    ST_RX_ACK = 5'b00100,
    ST_TX     = 5'b01000,
    ST_TX_ACK = 5'b10000
  } sas_state_e;

  typedef struct packed {
    logic        send_byte;   // pulse: command-only transfer done
    logic        write_word;  // pulse: permitted word write done
    logic        read_done;   // pulse: read word finished
    logic [7:0]  code;        // last command code, held
    logic [15:0] data;        // last written word, held
  } sas_evt_s;

  localparam sas_evt_s EVT_RST = '0;

  // level of one select pin as a weight 0..2
  function automatic logic [6:0] sel_weight(input logic [1:0] lvl);
    unique case (lvl)
      SEL_LOW:  sel_weight = 7'h00;
      SEL_OPEN: sel_weight = 7'h01;
      default:  sel_weight = 7'h02;
    endcase
  endfunction

endpackage

// >>> rtl/sas_slave.sv
/*
  sas_slave: serial slave front end of a supply sequencer: address decode,
  send-byte, write-word, read-word and alert response, alert drive.
  Assumes the register map sits on i_clk and presents the word for the held
  command code on i_rd_data; the pads resolve the open-drain lines.
*/
`timescale 1ns/1ns
// Functional notes
// - One of 27 strapped addresses is answered, set by three select pins.
// - The address is 0x37 + 9*c + 3*b + a, each select weighing 0, 1 or 2.
// - Global address 0x36 is acked with the write direction unless a store runs.
// - Alert response address 0001100 with read is recognised only while alert is set.
// - Select pins are sampled all the time; a new strapping acts at once.
// - Alert response: ack, return own address, master nacks and stops.
// - The bit after the address is 1 for read and 0 for write.
// - Faults are reported by pulling the open-drain alert line low.
// - Send-byte, write-word and read-word transfers are supported.
// - Two protection stages must both be released before a word write acts.
// - No byte is acknowledged while an EEPROM store runs.
// - Alert is released after an alert response or an alert clear read.
// - Word writes are allowed only while the write protect pin is low.
module sas_slave
  import sas_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_ce,
  input  wire logic        i_scl,
  input  wire logic        i_sda,
  input  wire logic [1:0]  i_addr_sel_in_a,
  input  wire logic [1:0]  i_addr_sel_in_b,
  input  wire logic [1:0]  i_addr_sel_in_c,
  input  wire logic        i_wp,
  input  wire logic        i_sw_unlock,
  input  wire logic        i_store_busy,
  input  wire logic        i_fault_evt,
  input  wire logic [15:0] i_rd_data,
  output logic             o_sda_o,
  output logic             o_sda_oe,
  output logic             o_alert_out_n_o,
  output logic             o_alert_out_n_oe,
  output sas_evt_s         o_evt
);

  // ==========================================================
  // pin synchronisers
  logic [SYNC_W-1:0] pins_s;

  sas_sync u_sync (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_ce      (i_ce),
    .i_async   ({i_addr_sel_in_c, i_addr_sel_in_b, i_addr_sel_in_a,
                 i_wp, i_sda, i_scl}),
    .o_sync    (pins_s)
  );

  // ==========================================================
  // state
  sas_state_e  st_reg;
  sas_state_e  st_next;
  logic        scl_d_reg;
  logic        scl_d_next;
  logic        sda_d_reg;
  logic        sda_d_next;
  logic [3:0]  bit_reg;
  logic [3:0]  bit_next;
  logic [7:0]  shift_reg;
  logic [7:0]  shift_next;
  logic [2:0]  byte_reg;
  logic [2:0]  byte_next;
  logic        rw_reg;
  logic        rw_next;
  logic        ara_reg;
  logic        ara_next;
  logic [15:0] tx_reg;
  logic [15:0] tx_next;
  logic        txsel_reg;
  logic        txsel_next;
  logic [3:0]  hold_reg;
  logic [3:0]  hold_next;
  logic        pend_reg;
  logic        pend_next;
  logic        sda_oe_reg;
  logic        sda_oe_next;
  logic        alert_reg;
  logic        alert_next;
  logic        clr_pend_reg;
  logic        clr_pend_next;
  logic        low_reg;
  sas_evt_s    evt_reg;
  sas_evt_s    evt_next;

  // ==========================================================
  // decoded pin views
  logic       scl_s;
  logic       sda_s;
  logic       scl_rise;
  logic       scl_fall;
  logic       bus_start;
  logic       bus_stop;
  logic       writable;
  logic [6:0] own_addr;
  logic [7:0] tx_byte;

  assign scl_s     = pins_s[SY_SCL];
  assign sda_s     = pins_s[SY_SDA];
  assign scl_rise  = scl_s & ~scl_d_reg;
  assign scl_fall  = ~scl_s & scl_d_reg;
  assign bus_start = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  assign bus_stop  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

  // strapped address, live from the pins
  assign own_addr  = ADDR_BASE
                   + 7'(9) * sel_weight(pins_s[SY_SEL_C +: 2])
                   + 7'(3) * sel_weight(pins_s[SY_SEL_B +: 2])
                   + sel_weight(pins_s[SY_SEL_A +: 2]);

  // both stages must be open
  assign writable  = ~pins_s[SY_WP] & i_sw_unlock;
  assign tx_byte   = txsel_reg ? tx_reg[15:8] : tx_reg[7:0];

  // ==========================================================
  // protocol engine, alert and events
  always_comb begin
    logic       ack;
    logic       hit_own;
    logic       hit_glb;
    logic       hit_ara;
    logic       do_clear;
    logic [6:0] rx_addr;
    ack           = 1'b0;
    do_clear      = 1'b0;
    rx_addr       = shift_reg[7:1];
    hit_own       = (rx_addr == own_addr);
    hit_glb       = (rx_addr == ADDR_GLOBAL)
                  & (shift_reg[0] == DIR_WRITE);
    hit_ara       = (rx_addr == ADDR_ALERT_RESP)
                  & (shift_reg[0] == DIR_READ) & alert_reg;
    st_next       = st_reg;
    scl_d_next    = scl_d_reg;
    sda_d_next    = sda_d_reg;
    bit_next      = bit_reg;
    shift_next    = shift_reg;
    byte_next     = byte_reg;
    rw_next       = rw_reg;
    ara_next      = ara_reg;
    tx_next       = tx_reg;
    txsel_next    = txsel_reg;
    hold_next     = hold_reg;
    pend_next     = pend_reg;
    sda_oe_next   = sda_oe_reg;
    alert_next    = alert_reg;
    clr_pend_next = clr_pend_reg;
    evt_next      = evt_reg;
    if (i_ce) begin
      scl_d_next         = scl_s;
      sda_d_next         = sda_s;
      evt_next.send_byte  = 1'b0;
      evt_next.write_word = 1'b0;
      evt_next.read_done  = 1'b0;
      // delayed drive keeps the data hold time after scl falls
      if (hold_reg != 4'h0) begin
        hold_next = hold_reg - 4'h1;
        if (hold_reg == 4'h1) begin
          sda_oe_next = pend_reg;
        end
      end
      if (bus_stop) begin
        // end of transfer: release and report
        st_next       = ST_IDLE;
        hold_next     = 4'h0;
        pend_next     = 1'b0;
        sda_oe_next   = 1'b0;
        do_clear      = clr_pend_reg;
        clr_pend_next = 1'b0;
        evt_next.send_byte  = (rw_reg == DIR_WRITE)
                            & (byte_reg == CNT_SEND);
        evt_next.write_word = (rw_reg == DIR_WRITE) & writable
                            & (byte_reg == CNT_WORD);
      end else if (bus_start) begin
        // start or repeated start: fresh address byte
        st_next     = ST_RX;
        bit_next    = 4'h0;
        byte_next   = BYTE_ADDR;
        hold_next   = 4'h0;
        pend_next   = 1'b0;
        sda_oe_next = 1'b0;
      end else begin
        unique case (st_reg)
          ST_RX: begin
            if (scl_rise && bit_reg != BITS_BYTE) begin
              shift_next = {shift_reg[6:0], sda_s};
              bit_next   = bit_reg + 4'h1;
            end else if (scl_fall && bit_reg == BITS_BYTE) begin
              unique case (byte_reg)
                BYTE_ADDR: begin
                  ack      = hit_own | hit_glb | hit_ara;
                  rw_next  = shift_reg[0];
                  ara_next = hit_ara & ~hit_own;
                  txsel_next = 1'b0;
                  tx_next  = ara_next ? {8'h00, own_addr, 1'b0}
                                      : i_rd_data;
                end
                BYTE_CMD: begin
                  ack           = 1'b1;
                  evt_next.code = shift_reg;
                end
                BYTE_LO: begin
                  ack                = 1'b1;
                  evt_next.data[7:0] = shift_reg;
                end
                BYTE_HI: begin
                  ack                 = 1'b1;
                  evt_next.data[15:8] = shift_reg;
                end
                default: ack = 1'b0;
              endcase
              ack = ack & ~i_store_busy;
              if (ack) begin
                st_next   = ST_RX_ACK;
                byte_next = byte_reg + 3'h1;
                pend_next = 1'b1;
                hold_next = HOLD_CYC_W;
              end else begin
                st_next = ST_IDLE;
              end
            end
          end
          ST_RX_ACK: begin
            // end of an ack slot: send next byte or take another
            if (scl_fall) begin
              hold_next = HOLD_CYC_W;
              if (rw_reg == DIR_READ) begin
                st_next    = ST_TX;
                shift_next = tx_byte;
                pend_next  = ~tx_byte[7];
                bit_next   = 4'h1;
              end else begin
                st_next   = ST_RX;
                pend_next = 1'b0;
                bit_next  = 4'h0;
              end
            end
          end
          ST_TX: begin
            if (scl_fall) begin
              hold_next = HOLD_CYC_W;
              if (bit_reg == BITS_BYTE) begin
                st_next   = ST_TX_ACK;
                pend_next = 1'b0;
              end else begin
                pend_next  = ~shift_reg[6];
                shift_next = {shift_reg[6:0], 1'b0};
                bit_next   = bit_reg + 4'h1;
              end
            end
          end
          ST_TX_ACK: begin
            // master acks for more, nacks to finish
            if (scl_rise) begin
              if (!sda_s) begin
                st_next    = ST_RX_ACK;
                txsel_next = ~txsel_reg;
              end else begin
                st_next = ST_IDLE;
                if (ara_reg) begin
                  clr_pend_next = 1'b1;
                end else if (txsel_reg) begin
                  evt_next.read_done = 1'b1;
                  if (evt_reg.code == CMD_ALERT_CLEAR) begin
                    clr_pend_next = 1'b1;
                  end
                end
              end
            end
          end
          default: st_next = ST_IDLE;  // idle, or a broken code
        endcase
      end
      // a fault in the clearing cycle keeps the alert set
      alert_next = (alert_reg & ~do_clear) | i_fault_evt;
    end
  end

  // register the engine
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      st_reg       <= ST_IDLE;
      scl_d_reg    <= 1'b1;
      sda_d_reg    <= 1'b1;
      bit_reg      <= 4'h0;
      shift_reg    <= 8'h00;
      byte_reg     <= BYTE_ADDR;
      rw_reg       <= DIR_WRITE;
      ara_reg      <= 1'b0;
      tx_reg       <= 16'h0000;
      txsel_reg    <= 1'b0;
      hold_reg     <= 4'h0;
      pend_reg     <= 1'b0;
      sda_oe_reg   <= 1'b0;
      alert_reg    <= 1'b0;
      clr_pend_reg <= 1'b0;
      low_reg      <= 1'b0;
      evt_reg      <= EVT_RST;
    end else begin
      st_reg       <= st_next;
      scl_d_reg    <= scl_d_next;
      sda_d_reg    <= sda_d_next;
      bit_reg      <= bit_next;
      shift_reg    <= shift_next;
      byte_reg     <= byte_next;
      rw_reg       <= rw_next;
      ara_reg      <= ara_next;
      tx_reg       <= tx_next;
      txsel_reg    <= txsel_next;
      hold_reg     <= hold_next;
      pend_reg     <= pend_next;
      sda_oe_reg   <= sda_oe_next;
      alert_reg    <= alert_next;
      clr_pend_reg <= clr_pend_next;
      low_reg      <= 1'b0;
      evt_reg      <= evt_next;
    end
  end

  // ==========================================================
  // outputs, all from flops; open-drain lines only ever pull low
  assign o_sda_o          = low_reg;
  assign o_sda_oe         = sda_oe_reg;
  assign o_alert_out_n_o  = low_reg;
  assign o_alert_out_n_oe = alert_reg;
  assign o_evt            = evt_reg;

endmodule

// >>> rtl/sas_sync.sv
/*
  sas_sync: two-stage synchroniser for a group of asynchronous inputs.
  Assumes every bit is a slow level; stage one is read by stage two only.
*/
`timescale 1ns/1ns
module sas_sync
  import sas_pkg::*;
(
  input  wire logic              i_clk,
  input  wire logic              i_sys_rst,
  input  wire logic              i_ce,
  input  wire logic [SYNC_W-1:0] i_async,
  output logic      [SYNC_W-1:0] o_sync
);

  // ==========================================================
  // stages
  logic [SYNC_W-1:0] meta_reg;
  logic [SYNC_W-1:0] meta_next;
  logic [SYNC_W-1:0] sync_reg;
  logic [SYNC_W-1:0] sync_next;

  // hold everything while the clock enable is low
  always_comb begin
    meta_next = meta_reg;
    sync_next = sync_reg;
    if (i_ce) begin
      meta_next = i_async;
      sync_next = meta_reg;
    end
  end

  // register both stages
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      meta_reg <= SYNC_RST;
      sync_reg <= SYNC_RST;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign o_sync = sync_reg;

endmodule

// >>> verif/sas_i2c_master.sv
/*
  sas_i2c_master: bus master model driving SCL and SDA from tasks.
  Assumes SDA is resolved outside with a pull-up; a released line reads 1.
*/
`timescale 1ns/1ns
module sas_i2c_master #(
  parameter int unsigned STEP = 8
) (
  input  wire logic i_clk,
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda_oe
);
  // ==========================================================
  // bus phases of STEP core clocks; scl low for two of them
  initial begin
    o_scl    = 1'b1;
    o_sda_oe = 1'b0;
  end

  task automatic wt(input int n);
    repeat (n) @(posedge i_clk);
  endtask

  // start or repeated start, ends with scl low
  task automatic start();
    wt(STEP);
    o_sda_oe <= 1'b0;
    wt(STEP);
    o_scl    <= 1'b1;
    wt(STEP);
    o_sda_oe <= 1'b1;
    wt(STEP);
    o_scl    <= 1'b0;
  endtask

  // stop, then idle bus
  task automatic stop();
    wt(STEP);
    o_sda_oe <= 1'b1;
    wt(STEP);
    o_scl    <= 1'b1;
    wt(STEP);
    o_sda_oe <= 1'b0;
    wt(2 * STEP);
  endtask

  // one bit: drive b (1 releases), sample in mid high
  task automatic bit_io(input logic b, output logic r);
    wt(STEP);
    o_sda_oe <= !b;
    wt(STEP);
    o_scl    <= 1'b1;
    wt(STEP / 2);
    r = i_sda;
    wt(STEP / 2);
    o_scl    <= 1'b0;
  endtask

  // eight bits msb first, then the ack bit
  task automatic byte_io(input logic [7:0] tx, input logic ak_in,
                         output logic [7:0] rx, output logic ak);
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], rx[i]);
    end
    bit_io(ak_in, ak);
  endtask
endmodule

// >>> verif/sas_slave_properties.sv
/*
  sas_slave_properties: timing checks on the slave's ports.
  Assumes one clock domain and the bind at the foot of this file.
*/
`timescale 1ns/1ns
module sas_slave_properties
  import sas_pkg::*;
(
  input wire logic        i_clk,
  input wire logic        i_sys_rst,
  input wire logic        i_ce,
  input wire logic        i_scl,
  input wire logic        i_sda,
  input wire logic [1:0]  i_addr_sel_in_a,
  input wire logic [1:0]  i_addr_sel_in_b,
  input wire logic [1:0]  i_addr_sel_in_c,
  input wire logic        i_wp,
  input wire logic        i_sw_unlock,
  input wire logic        i_store_busy,
  input wire logic        i_fault_evt,
  input wire logic [15:0] i_rd_data,
  input wire logic        o_sda_o,
  input wire logic        o_sda_oe,
  input wire logic        o_alert_out_n_o,
  input wire logic        o_alert_out_n_oe,
  input wire sas_evt_s    o_evt
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  // ==========================================================
  // cycles scl has been low, saturating
  logic [3:0] low_cnt_reg;
  logic [3:0] low_cnt_next;
  logic       pulse;

  always_comb begin
    low_cnt_next = low_cnt_reg + ((low_cnt_reg != 4'hF) ? 4'h1 : 4'h0);
    if (i_scl) begin
      low_cnt_next = 4'h0;
    end
  end

  always_ff @(posedge i_clk) begin
    low_cnt_reg <= low_cnt_next;
  end

  assign pulse = o_evt.send_byte | o_evt.write_word | o_evt.read_done;

  // ==========================================================
  // properties
  property p_rst_quiet;
    @(posedge i_clk) disable iff (1'b0)
    i_sys_rst |=> !o_sda_oe && !o_alert_out_n_oe && o_evt == EVT_RST;
  endproperty
  property p_open_drain;
    o_sda_o == 1'b0 && o_alert_out_n_o == 1'b0;
  endproperty
  property p_fault_sets;
    i_fault_evt && i_ce |=> o_alert_out_n_oe;
  endproperty
  property p_alert_cause;
    $rose(o_alert_out_n_oe) |-> $past(i_fault_evt);
  endproperty
  property p_alert_release;
    $fell(o_alert_out_n_oe) && !$past(i_sys_rst)
      |-> i_scl && i_sda && !$past(i_fault_evt);
  endproperty
  property p_wr_gate;
    o_evt.write_word |-> !$past(i_wp, 3) && $past(i_sw_unlock);
  endproperty
  property p_one_pulse;
    pulse |=> (!pulse) [*8];
  endproperty
  property p_hold;
    $changed(o_sda_oe) && !$past(i_sys_rst) |-> low_cnt_reg >= HOLD_CYC_W;
  endproperty

  a_rst_quiet: assert property (p_rst_quiet)
    else $error("outputs not cleared by reset");
  a_open_drain: assert property (p_open_drain)
    else $error("open drain data level not low");
  a_fault_sets: assert property (p_fault_sets)
    else $error("fault did not raise alert");
  a_alert_cause: assert property (p_alert_cause)
    else $error("alert raised without fault");
  a_alert_release: assert property (p_alert_release)
    else $error("alert released outside stop");
  a_wr_gate: assert property (p_wr_gate)
    else $error("word write passed while protected");
  a_one_pulse: assert property (p_one_pulse)
    else $error("event pulse too long");
  a_hold: assert property (p_hold)
    else $error("sda changed too soon after scl fall");

  c_send: cover property (o_evt.send_byte);
  c_write: cover property (o_evt.write_word);
  c_read: cover property (o_evt.read_done);
  c_clear: cover property ($fell(o_alert_out_n_oe));
endmodule

bind sas_slave sas_slave_properties chk_u (
  .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_ce(i_ce), .i_scl(i_scl),
  .i_sda(i_sda), .i_addr_sel_in_a(i_addr_sel_in_a),
  .i_addr_sel_in_b(i_addr_sel_in_b), .i_addr_sel_in_c(i_addr_sel_in_c),
  .i_wp(i_wp), .i_sw_unlock(i_sw_unlock), .i_store_busy(i_store_busy),
  .i_fault_evt(i_fault_evt), .i_rd_data(i_rd_data), .o_sda_o(o_sda_o),
  .o_sda_oe(o_sda_oe), .o_alert_out_n_o(o_alert_out_n_o),
  .o_alert_out_n_oe(o_alert_out_n_oe), .o_evt(o_evt)
);

// >>> verif/sas_slave_tb.sv
/*
  sas_slave_tb: self-checking bench for the serial slave front end.
  Assumes the master model and the bound checker; SDA has a pull-up.
*/
`timescale 1ns/1ns
module sas_slave_tb;
  import sas_pkg::*;

  // ==========================================================
  // stimulus, wires and bookkeeping
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [1:0]  sel_a = 2'h0, sel_b = 2'h0, sel_c = 2'h0;
  logic        wp = 1'b0, unlock = 1'b1, busy = 1'b0, fault = 1'b0;
  logic        ce = 1'b1;
  logic [15:0] rd_data = 16'h0000;
  logic [31:0] rnd = 32'hE30A;
  logic [6:0]  own;
  logic        scl, m_oe, sda_oe, alert_oe;
  sas_evt_s    evt;
  wire         sda_w = !(m_oe || sda_oe);
  logic [26:0] exp_q[$];
  int          bad_count = 0;
  int          num_checks = 0;

  always #25 clk = ~clk;

  sas_slave dut_u (
    .i_clk(clk), .i_sys_rst(rst), .i_ce(ce), .i_scl(scl), .i_sda(sda_w),
    .i_addr_sel_in_a(sel_a), .i_addr_sel_in_b(sel_b),
    .i_addr_sel_in_c(sel_c), .i_wp(wp), .i_sw_unlock(unlock),
    .i_store_busy(busy), .i_fault_evt(fault), .i_rd_data(rd_data),
    .o_sda_o(), .o_sda_oe(sda_oe), .o_alert_out_n_o(),
    .o_alert_out_n_oe(alert_oe), .o_evt(evt)
  );

  sas_i2c_master m_u (
    .i_clk(clk), .i_sda(sda_w), .o_scl(scl), .o_sda_oe(m_oe)
  );

  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic chk(input string nm, input logic [27:0] e,
                     input logic [27:0] g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic print_verdict();
    if (bad_count == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ==========================================================
  // byte and transfer helpers
  task automatic put(input logic [7:0] b, input logic e);
    logic [7:0] rx;
    logic       ak;
    m_u.byte_io(b, 1'b1, rx, ak);
    chk("ack", 28'(e), 28'(ak));
  endtask

  task automatic get(input logic [7:0] e, input logic last);
    logic [7:0] rx;
    logic       ak;
    m_u.byte_io(8'hFF, last, rx, ak);
    chk("rdata", 28'(e), 28'(rx));
  endtask

  task automatic nak(input logic [7:0] a8);
    m_u.start();
    put(a8, 1'b1);
    m_u.stop();
  endtask

  // k: 0 send byte, 1 write word, 2 read word
  task automatic xfer(input logic [6:0] a, input logic [1:0] k,
                      input logic [7:0] cmd, input logic [15:0] w,
                      input logic ok);
    m_u.start();
    put({a, DIR_WRITE}, 1'b0);
    put(cmd, 1'b0);
    if (ok) begin
      exp_q.push_back({k == 2'h0, k, cmd, (k == 2'h1) ? w : 16'h0000});
    end
    if (k == 2'h1) begin
      put(w[7:0], 1'b0);
      put(w[15:8], 1'b0);
    end else if (k == 2'h2) begin
      m_u.start();
      put({a, DIR_READ}, 1'b0);
      get(w[7:0], 1'b0);
      get(w[15:8], 1'b1);
    end
    m_u.stop();
  endtask

  // event watcher, oldest note first
  always @(posedge clk) begin
    if (evt.send_byte || evt.write_word || evt.read_done) begin
      chk("event", (exp_q.size() != 0) ? 28'(exp_q.pop_front())
          : 28'hFFFFFFF, 28'({evt.send_byte, evt.read_done, evt.write_word,
          evt.code, evt.write_word ? evt.data : 16'h0000}));
    end
  end

  // watchdog
  initial begin
    repeat (60000) @(posedge clk);
    bad_count++;
    print_verdict();
  end

  // ==========================================================
  // main sequence
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    chk("idle", 28'h0, 28'({sda_oe, evt}));
    chk("idle alert", 28'h0, 28'(alert_oe));
    for (int c = 0; c < 3; c++) begin
      for (int b = 0; b < 3; b++) begin
        for (int a = 0; a < 3; a++) begin
          rnd = xs(rnd);
          sel_a <= 2'(a);
          sel_b <= 2'(b);
          sel_c <= (c == 2 && rnd[0]) ? 2'h3 : 2'(c);
          own = ADDR_BASE + 7'(9 * c + 3 * b + a);
          repeat (4) @(posedge clk);
          xfer(own, 2'h0, rnd[15:8], 16'h0000, 1'b1);
          nak({own + 7'h01, DIR_WRITE});
        end
      end
    end
    rnd = xs(rnd);
    xfer(ADDR_GLOBAL, 2'h0, rnd[7:0], 16'h0000, 1'b1);
    nak({ADDR_GLOBAL, DIR_READ});
    xfer(own, 2'h1, rnd[15:8], rnd[31:16], 1'b1);
    wp <= 1'b1;
    xfer(own, 2'h1, rnd[7:0], rnd[23:8], 1'b0);
    wp <= 1'b0;
    unlock <= 1'b0;
    xfer(own, 2'h1, rnd[7:0], rnd[23:8], 1'b0);
    unlock <= 1'b1;
    rnd = xs(rnd);
    rd_data <= rnd[15:0];
    xfer(own, 2'h2, rnd[23:16], rnd[15:0], 1'b1);
    nak({ADDR_ALERT_RESP, DIR_READ});
    ce <= 1'b0;
    fault <= 1'b1;
    repeat (4) @(posedge clk);
    chk("frozen alert", 28'h0, 28'(alert_oe));
    ce <= 1'b1;
    @(posedge clk);
    fault <= 1'b0;
    repeat (3) @(posedge clk);
    chk("alert", 28'h1, 28'(alert_oe));
    m_u.start();
    put({ADDR_ALERT_RESP, DIR_READ}, 1'b0);
    get({own, 1'b0}, 1'b1);
    m_u.stop();
    chk("alert", 28'h0, 28'(alert_oe));
    fault <= 1'b1;
    @(posedge clk);
    fault <= 1'b0;
    repeat (2) @(posedge clk);
    chk("alert", 28'h1, 28'(alert_oe));
    xfer(own, 2'h2, CMD_ALERT_CLEAR, rnd[15:0], 1'b1);
    chk("alert", 28'h0, 28'(alert_oe));
    busy <= 1'b1;
    nak({own, DIR_WRITE});
    busy <= 1'b0;
    repeat (20) @(posedge clk);
    chk("pending", 28'h0, 28'(exp_q.size()));
    print_verdict();
  end
endmodule
